// ### design/sr_pkg.sv
// constants, field layout and types of the serial receiver
package sr_pkg;
   // ************
   // register indices and byte addresses
   // ************
   localparam logic [1:0] IDX_BAUD = 2'h0;
   localparam logic [1:0] IDX_CTRL = 2'h1;
   localparam logic [1:0] IDX_STAT = 2'h2;
   localparam logic [1:0] IDX_DATA = 2'h3;
   localparam logic [4:0] ADDR_BAUD = 5'h00;
   localparam logic [4:0] ADDR_CTRL = 5'h04;
   localparam logic [4:0] ADDR_STAT = 5'h08;
   localparam logic [4:0] ADDR_DATA = 5'h0C;
   // ************
   // field positions
   // ************
   localparam int CTL_NINE = 12;
   localparam int CTL_WAKE = 11;
   localparam int CTL_POL = 10;
   localparam int CTL_RX_FULL_IRQ_ENABLE = 5;
   localparam int CTL_RE = 2;
   localparam int CTL_RWU = 1;
   localparam int ST_FULL = 13;
   localparam int ST_QUIET = 12;
   localparam int ST_OVR = 11;
   localparam int ST_NF = 10;
   localparam int ST_FE = 9;
   // ************
   // reset values
   // ************
   localparam logic [12:0] BAUD_RST = 13'h0040;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   // ************
   // oversampling figures and bus response codes
   // ************
   localparam logic [4:0] RT_LAST = 5'h10;
   localparam logic [4:0] RT_V1 = 5'h03;
   localparam logic [4:0] RT_V2 = 5'h05;
   localparam logic [4:0] RT_V3 = 5'h07;
   localparam logic [4:0] RT_D1 = 5'h08;
   localparam logic [4:0] RT_D2 = 5'h09;
   localparam logic [4:0] RT_D3 = 5'h0A;
   localparam logic [7:0] IDLE_T8 = 8'hA0;
   localparam logic [7:0] IDLE_T9 = 8'hB0;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   // ************
   // types
   // ************
   typedef enum logic [1:0] {
      RX_HUNT = 2'h0,
      RX_START = 2'h1,
      RX_DATA = 2'h3,
      RX_STOP = 2'h2
   } sr_rx_state_t;
   typedef struct packed {
      logic full;
      logic quiet;
      logic ovr;
      logic nf;
      logic fe;
   } sr_flags_t;
   typedef struct packed {
      logic done;
      logic fe;
      logic nf;
      logic [8:0] data;
   } sr_frame_t;
endpackage : sr_pkg

// ### design/sr_rx.sv
// serial receiver with oversampling, flags and register slave
//
// Chosen here: the register offsets and the AXI4-Lite slave port.
module sr_rx import sr_pkg::*; #(
   parameter int ADDR_W = 5
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus write
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // register bus read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // serial line and interrupt
   input wire logic rx_pin,
   output logic rx_irq
);
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic maj3(input logic [2:0] v);
      return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction : maj3

   function automatic logic split3(input logic [2:0] v);
      return (v != 3'b000) && (v != 3'b111);
   endfunction : split3

   function automatic logic [15:0] merge16(input logic [15:0] old,
         input logic [31:0] d, input logic [3:0] strb);
      logic [15:0] r;
      r = old;
      if (strb[0]) begin
         r[7:0] = d[7:0];
      end
      if (strb[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction : merge16

   // ****************************************
   // declarations
   // ****************************************
   logic rx_meta_reg, rx_sync_reg;
   logic [12:0] baud_reg;
   logic [15:0] ctl_reg;
   logic [12:0] div_cnt_reg;
   logic tick_reg;
   sr_rx_state_t st_reg;
   logic [4:0] rt_reg;
   logic [3:0] bit_cnt_reg;
   logic [2:0] hist_reg, smp_reg;
   logic [8:0] shift_reg;
   logic noise_reg;
   logic [7:0] idle_cnt_reg;
   logic idle_reg;
   sr_frame_t frm_reg;
   sr_flags_t flg_reg;
   logic [8:0] data_reg;
   logic armed_reg;
   logic aw_have_reg, w_have_reg;
   logic [1:0] aw_idx_reg;
   logic aw_bad_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;
   logic irq_reg;
   logic rx_s, fall, bit_end, nine, wake, rx_standby;
   logic [2:0] v3;
   logic wr_fire, ar_fire;
   logic [1:0] ar_idx;
   logic ar_bad;
   logic msb, deliver, wake_clr;
   logic [7:0] idle_len;

   // ****************************************
   // input synchroniser and decodes
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_meta_reg <= 1'b1;
         rx_sync_reg <= 1'b1;
      end else begin
         rx_meta_reg <= rx_pin;
         rx_sync_reg <= rx_meta_reg;
      end
   end

   assign rx_s = rx_sync_reg ^ ctl_reg[CTL_POL];
   assign nine = ctl_reg[CTL_NINE];
   assign wake = ctl_reg[CTL_WAKE];
   assign rx_standby = ctl_reg[CTL_RWU];
   assign v3 = {smp_reg[1:0], rx_s};
   assign fall = hist_reg[0] & ~rx_s;
   assign bit_end = (rt_reg == RT_LAST) || ((rt_reg > RT_D3) && fall);
   assign idle_len = nine ? IDLE_T9 : IDLE_T8;
   assign wr_fire = aw_have_reg & w_have_reg & ~bvalid_reg;
   assign ar_fire = s_axi_arvalid & arready_reg;
   assign ar_idx = s_axi_araddr[3:2];
   assign ar_bad = (s_axi_araddr[ADDR_W-1:4] != '0);
   assign msb = nine ? frm_reg.data[8] : frm_reg.data[7];
   // standby frames only pass when they carry the address mark
   assign deliver = frm_reg.done && (!rx_standby || (wake && msb));
   assign wake_clr = (frm_reg.done && rx_standby && wake && msb)
      || (idle_reg && rx_standby && !wake);

   // ****************************************
   // oversampling tick divider
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt_reg <= 13'h0000;
         tick_reg <= 1'b0;
      end else if (!ctl_reg[CTL_RE] || baud_reg == 13'h0000) begin
         div_cnt_reg <= 13'h0000;
         tick_reg <= 1'b0;
      end else if (div_cnt_reg >= baud_reg - 13'h0001) begin
         div_cnt_reg <= 13'h0000;
         tick_reg <= 1'b1;
      end else begin
         div_cnt_reg <= div_cnt_reg + 13'h0001;
         tick_reg <= 1'b0;
      end
   end

   // ****************************************
   // frame recovery
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= RX_HUNT;
         rt_reg <= 5'h00;
         bit_cnt_reg <= 4'h0;
         hist_reg <= 3'b000;
         smp_reg <= 3'b000;
         shift_reg <= 9'h000;
         noise_reg <= 1'b0;
         frm_reg <= '0;
      end else begin
         frm_reg.done <= 1'b0;
         if (tick_reg) begin
            hist_reg <= {hist_reg[1:0], rx_s};
            if (st_reg != RX_HUNT && rt_reg != RT_LAST) begin
               rt_reg <= rt_reg + 5'h01;
            end
            case (st_reg)
               RX_HUNT: begin
                  if (!flg_reg.fe && hist_reg == 3'b111 && !rx_s) begin
                     st_reg <= RX_START;
                     rt_reg <= 5'h01;
                     noise_reg <= 1'b0;
                  end
               end
               RX_START: begin
                  if (rt_reg == RT_V1 || rt_reg == RT_V2 || rt_reg == RT_V3
                        || rt_reg == RT_D1 || rt_reg == RT_D2) begin
                     smp_reg <= v3;
                  end
                  if (rt_reg == RT_V3) begin
                     if (maj3(v3)) begin
                        st_reg <= RX_HUNT;
                        rt_reg <= 5'h00;
                        hist_reg <= 3'b000;
                     end else if (v3 != 3'b000) begin
                        noise_reg <= 1'b1;
                     end
                  end else if (rt_reg == RT_D3 && v3 != 3'b000) begin
                     noise_reg <= 1'b1;
                  end else if (bit_end) begin
                     st_reg <= RX_DATA;
                     rt_reg <= 5'h01;
                     bit_cnt_reg <= 4'h0;
                  end
               end
               RX_DATA: begin
                  if (rt_reg == RT_D1 || rt_reg == RT_D2) begin
                     smp_reg <= v3;
                  end
                  if (rt_reg == RT_D3) begin
                     shift_reg <= {maj3(v3), shift_reg[8:1]};
                     if (split3(v3)) begin
                        noise_reg <= 1'b1;
                     end
                  end else if (bit_end) begin
                     rt_reg <= 5'h01;
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                     if (bit_cnt_reg == (nine ? 4'h8 : 4'h7)) begin
                        st_reg <= RX_STOP;
                     end
                  end
               end
               RX_STOP: begin
                  if (rt_reg == RT_D1 || rt_reg == RT_D2) begin
                     smp_reg <= v3;
                  end
                  if (rt_reg == RT_D3) begin
                     st_reg <= RX_HUNT;
                     rt_reg <= 5'h00;
                     frm_reg.done <= 1'b1;
                     frm_reg.fe <= ~maj3(v3);
                     frm_reg.nf <= noise_reg | split3(v3);
                     frm_reg.data <= nine ? shift_reg : {1'b0, shift_reg[8:1]};
                  end
               end
               default: begin
                  st_reg <= RX_HUNT;
               end
            endcase
         end
      end
   end

   // ****************************************
   // idle line detection
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         idle_cnt_reg <= 8'h00;
         idle_reg <= 1'b0;
      end else begin
         idle_reg <= 1'b0;
         if (tick_reg) begin
            if (!rx_s || st_reg != RX_HUNT) begin
               idle_cnt_reg <= 8'h00;
            end else if (idle_cnt_reg == idle_len - 8'h01) begin
               idle_cnt_reg <= idle_cnt_reg + 8'h01;
               idle_reg <= 1'b1;
            end else if (idle_cnt_reg < idle_len) begin
               idle_cnt_reg <= idle_cnt_reg + 8'h01;
            end
         end
      end
   end

   // ****************************************
   // status flags and received data
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flg_reg <= '0;
         data_reg <= 9'h000;
         armed_reg <= 1'b0;
      end else begin
         if (ar_fire && !ar_bad && ar_idx == IDX_STAT) begin
            armed_reg <= 1'b1;
         end
         if (ar_fire && !ar_bad && ar_idx == IDX_DATA && armed_reg) begin
            flg_reg.full <= 1'b0;
            armed_reg <= 1'b0;
         end
         if (wr_fire && !aw_bad_reg && aw_idx_reg == IDX_STAT && armed_reg) begin
            flg_reg.fe <= 1'b0;
            flg_reg.nf <= 1'b0;
            flg_reg.ovr <= 1'b0;
            armed_reg <= 1'b0;
         end
         if (idle_reg && !(rx_standby && !wake)) begin
            flg_reg.quiet <= 1'b1;
         end
         if (frm_reg.done) begin
            flg_reg.quiet <= 1'b0;
         end
         if (deliver) begin
            if (flg_reg.full) begin
               flg_reg.ovr <= 1'b1;
            end else begin
               data_reg <= frm_reg.data;
            end
            flg_reg.full <= 1'b1;
            if (frm_reg.fe) begin
               flg_reg.fe <= 1'b1;
            end
            if (frm_reg.nf) begin
               flg_reg.nf <= 1'b1;
            end
         end
      end
   end

   // ****************************************
   // baud and control registers
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         baud_reg <= BAUD_RST;
         ctl_reg <= CTRL_RST;
      end else begin
         if (wake_clr) begin
            ctl_reg[CTL_RWU] <= 1'b0;
         end
         if (wr_fire && !aw_bad_reg && aw_idx_reg == IDX_CTRL) begin
            ctl_reg <= merge16(ctl_reg, wdata_reg, wstrb_reg);
         end
         if (wr_fire && !aw_bad_reg && aw_idx_reg == IDX_BAUD) begin
            baud_reg <= 13'(merge16({3'b000, baud_reg}, wdata_reg, wstrb_reg));
         end
      end
   end

   // ****************************************
   // interrupt request
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= flg_reg.full & ctl_reg[CTL_RX_FULL_IRQ_ENABLE] & ~rx_standby;
      end
   end

   // ****************************************
   // bus write channels
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         aw_idx_reg <= 2'h0;
         aw_bad_reg <= 1'b0;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OK;
      end else begin
         if (s_axi_awvalid && awready_reg) begin
            aw_have_reg <= 1'b1;
            aw_idx_reg <= s_axi_awaddr[3:2];
            aw_bad_reg <= (s_axi_awaddr[ADDR_W-1:4] != '0);
            awready_reg <= 1'b0;
         end
         if (s_axi_wvalid && wready_reg) begin
            w_have_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
            wready_reg <= 1'b0;
         end
         if (wr_fire) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= aw_bad_reg ? RESP_ERR : RESP_OK;
         end
         if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
         end
      end
   end

   // ****************************************
   // bus read channels
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= RESP_OK;
      end else begin
         if (ar_fire) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rresp_reg <= ar_bad ? RESP_ERR : RESP_OK;
            rdata_reg <= 32'h00000000;
            if (!ar_bad) begin
               case (ar_idx)
                  IDX_BAUD: rdata_reg <= {19'h00000, baud_reg};
                  IDX_CTRL: rdata_reg <= {16'h0000, ctl_reg};
                  IDX_STAT: begin
                     rdata_reg[ST_FULL] <= flg_reg.full;
                     rdata_reg[ST_QUIET] <= flg_reg.quiet;
                     rdata_reg[ST_OVR] <= flg_reg.ovr;
                     rdata_reg[ST_NF] <= flg_reg.nf;
                     rdata_reg[ST_FE] <= flg_reg.fe;
                  end
                  IDX_DATA: rdata_reg <= {23'h000000, data_reg};
                  default: rdata_reg <= 32'h00000000;
               endcase
            end
         end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
         end
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign rx_irq = irq_reg;
endmodule : sr_rx

// ### testbench/sr_rx_props.sv
// concurrent checks on the serial receiver ports
module sr_rx_props import sr_pkg::*; #(
   parameter int ADDR_W = 5
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus write
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // register bus read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // serial line and interrupt
   input wire logic rx_pin,
   input wire logic rx_irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   logic [ADDR_W-1:0] aw_q, ar_q;
   logic [31:0] wd_q;
   logic ws_q, ie_q, fe_q, armed_q, clr_q, drd_q;
   logic aw_hs, w_hs, ar_hs, b_hs, r_hs, st_rd, d_rd;
   assign aw_hs = s_axi_awvalid && s_axi_awready;
   assign w_hs = s_axi_wvalid && s_axi_wready;
   assign ar_hs = s_axi_arvalid && s_axi_arready;
   assign b_hs = s_axi_bvalid && s_axi_bready;
   assign r_hs = s_axi_rvalid && s_axi_rready;
   assign st_rd = r_hs && ar_q == ADDR_W'(ADDR_STAT);
   assign d_rd = r_hs && ar_q == ADDR_W'(ADDR_DATA);
   // ************
   // bus capture and enable shadow
   // ************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= '0;
         ar_q <= '0;
         wd_q <= '0;
         ws_q <= 1'b0;
         ie_q <= 1'b0;
      end else begin
         if (aw_hs) aw_q <= s_axi_awaddr;
         if (ar_hs) ar_q <= s_axi_araddr;
         if (w_hs) wd_q <= s_axi_wdata;
         if (w_hs) ws_q <= s_axi_wstrb[0];
         if (b_hs && aw_q == ADDR_W'(ADDR_CTRL) && ws_q) ie_q <= wd_q[CTL_RX_FULL_IRQ_ENABLE];
      end
   end
   // ************
   // error flag clear tracking
   // ************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fe_q <= 1'b0;
         armed_q <= 1'b0;
         clr_q <= 1'b0;
         drd_q <= 1'b0;
      end else if (st_rd) begin
         fe_q <= s_axi_rdata[ST_FE];
         armed_q <= 1'b1;
         clr_q <= 1'b0;
         drd_q <= 1'b0;
      end else if (d_rd) begin
         armed_q <= 1'b0;
         drd_q <= 1'b1;
      end else if (b_hs && aw_q == ADDR_W'(ADDR_STAT)) begin
         clr_q <= clr_q | armed_q;
         armed_q <= 1'b0;
      end
   end
   // ************
   // assertions
   // ************
   AST_B_AFTER_AW_W: assert property (aw_hs && w_hs |=> ##1 s_axi_bvalid)
      else $error("write response late");
   AST_B_DROP: assert property (b_hs |=> !s_axi_bvalid)
      else $error("write response not released");
   AST_R_AFTER_AR: assert property (ar_hs |=> s_axi_rvalid)
      else $error("read data late");
   AST_R_DROP: assert property (r_hs |=> !s_axi_rvalid)
      else $error("read data not released");
   AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("address taken during read");
   AST_UNMAPPED: assert property (ar_hs && s_axi_araddr[ADDR_W-1]
      |=> s_axi_rresp == RESP_ERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   AST_IRQ_ENABLE: assert property (rx_irq |-> ie_q)
      else $error("interrupt without enable");
   AST_FE_CLEAR: assert property (st_rd && fe_q && !s_axi_rdata[ST_FE] |-> clr_q)
      else $error("framing error cleared without read then write");
   AST_FE_WITH_FULL: assert property (st_rd && s_axi_rdata[ST_FE] && !fe_q && !drd_q
      |-> s_axi_rdata[ST_FULL])
      else $error("framing error without full flag");
   cover property (st_rd && s_axi_rdata[ST_FE]);
   cover property ($rose(rx_irq));
   cover property (b_hs && s_axi_bresp == RESP_ERR);
endmodule : sr_rx_props

bind sr_rx sr_rx_props #(.ADDR_W(ADDR_W)) sr_rx_props_inst (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .rx_pin(rx_pin), .rx_irq(rx_irq)
);

// ### testbench/sr_tx_model.sv
// remote transmitter model driving the serial line
module sr_tx_model (
   // clock and request
   input wire logic aclk,
   input wire logic send,
   input wire logic [8:0] data,
   input wire logic nine,
   input wire logic stop_val,
   input wire logic [15:0] bit_cyc,
   // status and line
   output logic busy,
   output logic line
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [10:0] frame;
   int nbits;
   initial begin
      line = 1'b1;
      busy = 1'b0;
      forever begin
         @(posedge aclk);
         if (send) begin
            busy <= 1'b1;
            frame = nine ? {stop_val, data, 1'b0} : {1'b1, stop_val, data[7:0], 1'b0};
            nbits = nine ? 11 : 10;
            for (int i = 0; i < nbits; i++) begin
               line <= frame[i];
               repeat (bit_cyc) @(posedge aclk);
            end
            line <= 1'b1;
            busy <= 1'b0;
         end
      end
   end
endmodule : sr_tx_model

// ### testbench/tb_sr_rx.sv
// self-checking bench for the serial receiver
module tb_sr_rx import sr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] M_RE = 32'h1 << CTL_RE, M_IE = 32'h1 << CTL_RX_FULL_IRQ_ENABLE,
      M_NINE = 32'h1 << CTL_NINE, M_WAKE = 32'h1 << CTL_WAKE, M_SB = 32'h1 << CTL_RWU,
      S_FULL = 32'h1 << ST_FULL, S_FE = 32'h1 << ST_FE, S_QUIET = 32'h1 << ST_QUIET,
      S_MASK = S_FULL | S_FE | (32'h1 << ST_NF) | (32'h1 << ST_OVR);
   logic aclk, aresetn, rx_line, rx_irq;
   logic [4:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic tx_send, tx_nine, tx_stop, tx_busy;
   logic [8:0] tx_data;
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   sr_rx #(.ADDR_W(5)) sr_rx_inst (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rx_pin(rx_line),
      .rx_irq(rx_irq));
   sr_tx_model sr_tx_model_inst (
      .aclk(aclk), .send(tx_send), .data(tx_data), .nine(tx_nine), .stop_val(tx_stop),
      .bit_cyc(16'h0020), .busy(tx_busy), .line(rx_line));
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   // ************
   // closing, compare, bus and serial send tasks
   // ************
   task automatic report_and_stop();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (s_axi_awready && !aw_ok) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready && !w_ok) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      r = s_axi_bresp;
   endtask : wr
   task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask : rd
   task automatic wreg(input logic [4:0] a, input logic [31:0] d);
      wr(a, d, rsp);
      chk({30'h0, rsp}, {30'h0, RESP_OK});
   endtask : wreg
   task automatic rchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
      rd(a, rd_val, rsp);
      chk(rd_val & m, e);
   endtask : rchk
   task automatic send(input logic [8:0] d, input logic n9, input logic sv);
      repeat (8) @(posedge aclk);
      tx_data <= d;
      tx_nine <= n9;
      tx_stop <= sv;
      tx_send <= 1'b1;
      do @(posedge aclk); while (!tx_busy);
      tx_send <= 1'b0;
      do @(posedge aclk); while (tx_busy);
   endtask : send
   task automatic irq_is(input logic e);
      repeat (2) @(posedge aclk);
      chk({31'h0, rx_irq}, {31'h0, e});
   endtask : irq_is
   // ************
   // main sequence
   // ************
   initial begin
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, tx_data} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, tx_send, tx_nine, tx_stop} = '0;
      s_axi_wstrb = 4'hF;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rchk(ADDR_BAUD, 32'hFFFF, {19'h0, BAUD_RST});
      rchk(ADDR_CTRL, 32'hFFFF, {16'h0, CTRL_RST});
      rchk(ADDR_STAT, 32'hFFFF, 32'h0);
      rd(5'h10, rd_val, rsp);
      chk({30'h0, rsp}, {30'h0, RESP_ERR});
      chk(rd_val, 32'h0);
      wr(5'h10, 32'h1234, rsp);
      chk({30'h0, rsp}, {30'h0, RESP_ERR});
      $display("test regs done");
      wreg(ADDR_BAUD, 32'h2);
      wreg(ADDR_CTRL, M_RE | M_IE);
      send(9'h0A5, 1'b0, 1'b1);
      irq_is(1'b1);
      rchk(ADDR_STAT, S_MASK, S_FULL);
      rchk(ADDR_DATA, 32'h1FF, 32'h0A5);
      irq_is(1'b0);
      wreg(ADDR_CTRL, M_RE | M_IE | M_NINE);
      send(9'h1A5, 1'b1, 1'b1);
      rchk(ADDR_STAT, S_MASK, S_FULL);
      rchk(ADDR_DATA, 32'h1FF, 32'h1A5);
      $display("test frames done");
      send(9'h13C, 1'b1, 1'b0);
      rchk(ADDR_STAT, S_MASK, S_FULL | S_FE);
      rchk(ADDR_DATA, 32'h1FF, 32'h13C);
      send(9'h055, 1'b1, 1'b1);
      rchk(ADDR_STAT, S_MASK, S_FE);
      wreg(ADDR_STAT, 32'h0);
      rchk(ADDR_STAT, S_MASK, 32'h0);
      send(9'h000, 1'b1, 1'b0);
      rchk(ADDR_STAT, S_MASK, S_FULL | S_FE);
      rchk(ADDR_DATA, 32'h1FF, 32'h0);
      wreg(ADDR_STAT, 32'h0);
      rchk(ADDR_STAT, S_FE, S_FE);
      wreg(ADDR_STAT, 32'h0);
      rchk(ADDR_STAT, S_MASK, 32'h0);
      $display("test errors done");
      wreg(ADDR_CTRL, M_RE | M_IE | M_WAKE | M_SB);
      send(9'h005, 1'b0, 1'b1);
      rchk(ADDR_STAT, S_MASK, 32'h0);
      send(9'h085, 1'b0, 1'b1);
      irq_is(1'b1);
      rchk(ADDR_CTRL, 32'hFFFF, M_RE | M_IE | M_WAKE);
      wreg(ADDR_CTRL, M_RE | M_IE | M_SB);
      irq_is(1'b0);
      rchk(ADDR_STAT, S_MASK, S_FULL);
      rchk(ADDR_DATA, 32'h1FF, 32'h085);
      repeat (400) @(posedge aclk);
      rchk(ADDR_CTRL, 32'hFFFF, M_RE | M_IE);
      rchk(ADDR_STAT, S_FULL | S_QUIET, 32'h0);
      $display("test standby done");
      report_and_stop();
   end
endmodule : tb_sr_rx
